// *** hdl/lcd_cmd_port.sv ***
`timescale 1ns/100ps
`include "lcd_port_defs.svh"

// Summary of operation
// - In parallel modes register select high marks data, low marks a command.
// - In serial modes the register select pad is the serial clock.
// - In 6800 mode the direction pin high reads, low writes.
// - In 8080 mode data is captured at the write strobe rising edge.
// - In 6800 writes data is captured at the enable falling edge.
// - In 8080 mode the bus is driven while read strobe is low, starting and ending one clock late.
// - Three select pins choose 8080, 6800, 4-line or 3-line serial.
// - Chip select is active low and gates every strobe.
// - Power save bit zero enters sleep, one leaves sleep.
// - Partial mode bit zero turns partial on, one turns it off.
// - Inverse bit zero is normal, one inverts pixels.
// - All-pixel bit zero forces pixels off, one forces them on.
// - Display bit zero blanks the panel, one enables output.
// - Column window takes four bytes, limits 00h to 7Fh, start not above end.
// - Row window takes four bytes, limits 00h to 9Fh, start not above end.
// - After write command, data bytes go to display memory at the position.
// - After read command, data reads return display memory at the position.
// - Partial area takes start and end rows, span 64 to 160 lines.
module lcd_cmd_port (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic reg_select_i,
    input wire logic write_dir_strobe_pin_i,
    input wire logic enable_read_strobe_pin_i,
    input wire logic bus_sel_lsb_i,
    input wire logic bus_sel_mid_i,
    input wire logic bus_sel_msb_i,
    input wire logic chip_select_n_i,
    input wire logic [7:0] data_i,
    output logic [7:0] data_o,
    output logic data_oe_n_o,
    output logic sleep_exit_bit_o,
    output logic partial_off_bit_o,
    output logic invert_bit_o,
    output logic all_pixels_bit_o,
    output logic display_on_o,
    input wire logic [4:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o
);
    function automatic lcd_port_pkg::bus_mode_t decode_mode(input logic [2:0] sel);
        case (sel)
            3'b110: decode_mode = lcd_port_pkg::BUS_I80;
            3'b100: decode_mode = lcd_port_pkg::BUS_M68;
            3'b011: decode_mode = lcd_port_pkg::BUS_SER4;
            3'b010: decode_mode = lcd_port_pkg::BUS_SER3;
            default: decode_mode = lcd_port_pkg::BUS_NONE;
        endcase
    endfunction

    function automatic logic win_ok(input logic [7:0] s_hi, input logic [7:0] s_lo,
                                    input logic [7:0] e_hi, input logic [7:0] e_lo,
                                    input logic [7:0] limit);
        win_ok = (s_hi == 8'h00) && (e_hi == 8'h00) && (e_lo <= limit) && (s_lo <= e_lo);
    endfunction

    function automatic logic [15:0] advance(input logic [7:0] col, input logic [7:0] row,
                                            input logic [7:0] cs, input logic [7:0] ce,
                                            input logic [7:0] rs, input logic [7:0] re);
        if (col != ce) begin
            advance = {row, 8'(col + 8'h01)};
        end else if (row != re) begin
            advance = {8'(row + 8'h01), cs};
        end else begin
            advance = {rs, cs};
        end
    endfunction

    lcd_port_pkg::bus_mode_t mode;
    lcd_port_pkg::dec_state_t state_q;
    logic port_en_q;
    logic wr_act, rd_act, wr_act_q, rd_act_q, rs_q, scl_q;
    logic [7:0] data_q;
    logic [8:0] shift_q;
    logic [3:0] bit_cnt_q;
    logic ev_valid_q, ev_rs_q;
    logic [7:0] ev_byte_q;
    logic [1:0] pcnt_q;
    logic [23:0] pbuf_q;
    logic [7:0] col_start_q, col_end_q, row_start_q, row_end_q, ptl_first_q, ptl_last_q;
    logic [7:0] col_ptr_q, row_ptr_q, ram_rdata;
    logic is_serial, scl_rise, par_byte, cmd_ev, data_ev, mem_we, rd_start, rd_done;
    logic [7:0] cmd_even;

    always_comb begin
        mode = decode_mode({bus_sel_msb_i, bus_sel_mid_i, bus_sel_lsb_i});
    end

    assign is_serial = (mode == lcd_port_pkg::BUS_SER4) || (mode == lcd_port_pkg::BUS_SER3);
    // Parallel strobes are only honoured while chip select is low.
    assign wr_act = !chip_select_n_i && (
        ((mode == lcd_port_pkg::BUS_I80) && !write_dir_strobe_pin_i) ||
        ((mode == lcd_port_pkg::BUS_M68) && enable_read_strobe_pin_i
            && !write_dir_strobe_pin_i));
    assign rd_act = !chip_select_n_i && (
        ((mode == lcd_port_pkg::BUS_I80) && !enable_read_strobe_pin_i) ||
        ((mode == lcd_port_pkg::BUS_M68) && enable_read_strobe_pin_i
            && write_dir_strobe_pin_i));
    // The strobe end is seen one clock late, so the byte sampled a clock earlier is used.
    assign par_byte = wr_act_q && !wr_act && port_en_q;
    assign scl_rise = is_serial && !chip_select_n_i && reg_select_i && !scl_q;
    assign rd_start = rd_act && !rd_act_q;
    assign rd_done = rd_act_q && !rd_act && rs_q && port_en_q
        && (state_q == lcd_port_pkg::ST_RD);
    assign cmd_ev = ev_valid_q && !ev_rs_q;
    assign data_ev = ev_valid_q && ev_rs_q;
    assign cmd_even = {ev_byte_q[7:1], 1'b0};
    assign mem_we = data_ev && (state_q == lcd_port_pkg::ST_WR);

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            wr_act_q <= 1'b0;
            rd_act_q <= 1'b0;
            rs_q <= 1'b0;
            scl_q <= 1'b0;
            data_q <= 8'h00;
        end else begin
            wr_act_q <= wr_act;
            rd_act_q <= rd_act;
            rs_q <= reg_select_i;
            scl_q <= reg_select_i;
            data_q <= data_i;
        end
    end

    // Serial data enters on data line 0; in 4-line mode data line 1 qualifies the byte.
    always_ff @(posedge mclk_i) begin
        if (rst_i || chip_select_n_i || !is_serial) begin
            shift_q <= 9'h000;
            bit_cnt_q <= 4'h0;
        end else if (scl_rise) begin
            shift_q <= {shift_q[7:0], data_i[0]};
            if ((mode == lcd_port_pkg::BUS_SER4 && bit_cnt_q == 4'h7) ||
                (mode == lcd_port_pkg::BUS_SER3 && bit_cnt_q == 4'h8)) begin
                bit_cnt_q <= 4'h0;
            end else begin
                bit_cnt_q <= 4'(bit_cnt_q + 4'h1);
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            ev_valid_q <= 1'b0;
            ev_rs_q <= 1'b0;
            ev_byte_q <= 8'h00;
        end else begin
            ev_valid_q <= 1'b0;
            if (par_byte) begin
                ev_valid_q <= 1'b1;
                ev_rs_q <= rs_q;
                ev_byte_q <= data_q;
            end else if (scl_rise && port_en_q && mode == lcd_port_pkg::BUS_SER4
                         && bit_cnt_q == 4'h7) begin
                ev_valid_q <= 1'b1;
                ev_rs_q <= data_i[1];
                ev_byte_q <= {shift_q[6:0], data_i[0]};
            end else if (scl_rise && port_en_q && mode == lcd_port_pkg::BUS_SER3
                         && bit_cnt_q == 4'h8) begin
                ev_valid_q <= 1'b1;
                ev_rs_q <= shift_q[7];
                ev_byte_q <= {shift_q[6:0], data_i[0]};
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i || (cmd_ev && ev_byte_q == `OP_SWRESET)) begin
            state_q <= lcd_port_pkg::ST_IDLE;
            pcnt_q <= 2'b00;
            pbuf_q <= 24'h00_0000;
            sleep_exit_bit_o <= `RST_SLEEP_EXIT;
            partial_off_bit_o <= `RST_PARTIAL_OFF;
            invert_bit_o <= `RST_INVERT;
            all_pixels_bit_o <= `RST_ALLPIX;
            display_on_o <= `RST_DISPLAY_ON;
            col_start_q <= 8'h00;
            col_end_q <= `COL_LIMIT;
            row_start_q <= 8'h00;
            row_end_q <= `ROW_LIMIT;
            ptl_first_q <= 8'h00;
            ptl_last_q <= `ROW_LIMIT;
        end else if (cmd_ev) begin
            // Any command ends a parameter or memory sequence; NOP does nothing else.
            state_q <= lcd_port_pkg::ST_IDLE;
            pcnt_q <= 2'b00;
            case (cmd_even)
                `OP_SLEEP: sleep_exit_bit_o <= ev_byte_q[0];
                `OP_PARTIAL: partial_off_bit_o <= ev_byte_q[0];
                `OP_INVERT: invert_bit_o <= ev_byte_q[0];
                `OP_ALLPIX: all_pixels_bit_o <= ev_byte_q[0];
                `OP_DISPLAY: display_on_o <= ev_byte_q[0];
                `OP_COLWIN: begin
                    state_q <= ev_byte_q[0] ? lcd_port_pkg::ST_ROW : lcd_port_pkg::ST_COL;
                end
                `OP_WRMEM: if (!ev_byte_q[0]) begin
                    state_q <= lcd_port_pkg::ST_WR;
                end
                `OP_RDMEM: if (!ev_byte_q[0]) begin
                    state_q <= lcd_port_pkg::ST_RD;
                end
                `OP_PTLAREA: if (!ev_byte_q[0]) begin
                    state_q <= lcd_port_pkg::ST_PTL;
                end
                default: ;
            endcase
        end else if (data_ev) begin
            unique case (state_q)
                lcd_port_pkg::ST_COL, lcd_port_pkg::ST_ROW, lcd_port_pkg::ST_PTL: begin
                    pbuf_q <= {pbuf_q[15:0], ev_byte_q};
                    pcnt_q <= 2'(pcnt_q + 2'b01);
                    if (pcnt_q == 2'b11) begin
                        state_q <= lcd_port_pkg::ST_IDLE;
                        // Out-of-range windows are dropped whole, keeping the old one.
                        if (state_q == lcd_port_pkg::ST_COL && win_ok(pbuf_q[23:16],
                            pbuf_q[15:8], pbuf_q[7:0], ev_byte_q, `COL_LIMIT)) begin
                            col_start_q <= pbuf_q[15:8];
                            col_end_q <= ev_byte_q;
                        end
                        if (state_q == lcd_port_pkg::ST_ROW && win_ok(pbuf_q[23:16],
                            pbuf_q[15:8], pbuf_q[7:0], ev_byte_q, `ROW_LIMIT)) begin
                            row_start_q <= pbuf_q[15:8];
                            row_end_q <= ev_byte_q;
                        end
                        if (state_q == lcd_port_pkg::ST_PTL && win_ok(pbuf_q[23:16],
                            pbuf_q[15:8], pbuf_q[7:0], ev_byte_q, `ROW_LIMIT)
                            && 8'(ev_byte_q - pbuf_q[15:8]) >= `PTL_MIN_SPAN) begin
                            ptl_first_q <= pbuf_q[15:8];
                            ptl_last_q <= ev_byte_q;
                        end
                    end
                end
                lcd_port_pkg::ST_IDLE, lcd_port_pkg::ST_WR, lcd_port_pkg::ST_RD: ;
                default: state_q <= lcd_port_pkg::ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i || (cmd_ev && ev_byte_q == `OP_SWRESET)) begin
            col_ptr_q <= 8'h00;
            row_ptr_q <= 8'h00;
        end else if (cmd_ev && (ev_byte_q == `OP_WRMEM || ev_byte_q == `OP_RDMEM)) begin
            col_ptr_q <= col_start_q;
            row_ptr_q <= row_start_q;
        end else if (mem_we || rd_done) begin
            {row_ptr_q, col_ptr_q} <= advance(col_ptr_q, row_ptr_q, col_start_q,
                                              col_end_q, row_start_q, row_end_q);
        end
    end

    display_ram_store u_ram (
        .mclk_i(mclk_i),
        .we_i(mem_we),
        .addr_i({row_ptr_q, col_ptr_q[6:0]}),
        .wdata_i(ev_byte_q),
        .rdata_o(ram_rdata)
    );

    // Drive follows the read strobe one clock late; the host's access time must allow it.
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            data_oe_n_o <= 1'b1;
            data_o <= 8'h00;
        end else begin
            data_oe_n_o <= !rd_act;
            if (rd_start) begin
                data_o <= (reg_select_i && port_en_q && state_q == lcd_port_pkg::ST_RD)
                    ? ram_rdata : 8'h00;
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            avs_waitrequest_o <= 1'b1;
            avs_readdata_o <= 32'h0000_0000;
            port_en_q <= `RST_PORT_EN;
        end else if ((avs_read_i || avs_write_i) && avs_waitrequest_o) begin
            avs_waitrequest_o <= 1'b0;
            avs_readdata_o <= 32'h0000_0000;
            if (avs_read_i) begin
                case (avs_address_i)
                    `REG_STATUS: avs_readdata_o <= {17'h0_0000, state_q, 1'b0, mode,
                        3'b000, display_on_o, all_pixels_bit_o, invert_bit_o,
                        partial_off_bit_o, sleep_exit_bit_o};
                    `REG_COLWIN: avs_readdata_o <= {8'h00, col_end_q, 8'h00, col_start_q};
                    `REG_ROWWIN: avs_readdata_o <= {8'h00, row_end_q, 8'h00, row_start_q};
                    `REG_PTLAREA: avs_readdata_o <= {8'h00, ptl_last_q, 8'h00, ptl_first_q};
                    `REG_CONTROL: avs_readdata_o <= {31'h0000_0000, port_en_q};
                    `REG_POSITION: avs_readdata_o <= {8'h00, row_ptr_q, 8'h00, col_ptr_q};
                    default: ;
                endcase
            end
        end else begin
            avs_waitrequest_o <= 1'b1;
            if (avs_write_i && !avs_waitrequest_o && avs_address_i == `REG_CONTROL) begin
                port_en_q <= avs_writedata_i[0];
            end
        end
    end

    a_oe_on_read: assert property (@(posedge mclk_i) disable iff (rst_i)
        rd_act |=> !data_oe_n_o) else $error("bus not driven during read");
    a_oe_released: assert property (@(posedge mclk_i) disable iff (rst_i)
        !rd_act |=> data_oe_n_o) else $error("bus driven outside read");
    a_byte_capture: assert property (@(posedge mclk_i) disable iff (rst_i)
        par_byte |=> ev_valid_q && ev_byte_q == $past(data_q) && ev_rs_q == $past(rs_q))
        else $error("strobe end did not capture the byte");
    a_nop_stable: assert property (@(posedge mclk_i) disable iff (rst_i)
        cmd_ev && ev_byte_q == `OP_NOP |=> $stable({sleep_exit_bit_o, partial_off_bit_o,
        invert_bit_o, all_pixels_bit_o, display_on_o, col_start_q, row_end_q}))
        else $error("nop changed a setting");
    a_swreset_dflt: assert property (@(posedge mclk_i) disable iff (rst_i)
        cmd_ev && ev_byte_q == `OP_SWRESET |=> !display_on_o && !sleep_exit_bit_o
        && partial_off_bit_o && col_end_q == `COL_LIMIT && state_q == lcd_port_pkg::ST_IDLE)
        else $error("software reset left a setting");
    a_sleep_bit: assert property (@(posedge mclk_i) disable iff (rst_i)
        cmd_ev && cmd_even == `OP_SLEEP |=> sleep_exit_bit_o == $past(ev_byte_q[0]))
        else $error("sleep bit not taken");
    a_invert_bit: assert property (@(posedge mclk_i) disable iff (rst_i)
        cmd_ev && cmd_even == `OP_INVERT |=> invert_bit_o == $past(ev_byte_q[0]))
        else $error("invert bit not taken");
    a_display_bit: assert property (@(posedge mclk_i) disable iff (rst_i)
        cmd_ev && cmd_even == `OP_DISPLAY |=> display_on_o == $past(ev_byte_q[0]))
        else $error("display bit not taken");
    a_ptr_wrap: assert property (@(posedge mclk_i) disable iff (rst_i)
        mem_we && col_ptr_q == col_end_q && row_ptr_q != row_end_q
        |=> col_ptr_q == $past(col_start_q) && row_ptr_q == 8'($past(row_ptr_q) + 8'h01))
        else $error("position did not wrap to next row");

    c_mem_write: cover property (@(posedge mclk_i) disable iff (rst_i) mem_we);
    c_mem_read: cover property (@(posedge mclk_i) disable iff (rst_i) rd_done);
    c_serial_byte: cover property (@(posedge mclk_i) disable iff (rst_i)
        is_serial && ev_valid_q);
endmodule

// *** shared/lcd_port_defs.svh ***
`ifndef LCD_PORT_DEFS_SVH
`define LCD_PORT_DEFS_SVH

// Command opcodes, with the setting bit cleared where there is one.
`define OP_NOP 8'h00
`define OP_SWRESET 8'h01
`define OP_SLEEP 8'h10
`define OP_PARTIAL 8'h12
`define OP_INVERT 8'h20
`define OP_ALLPIX 8'h22
`define OP_DISPLAY 8'h28
`define OP_COLWIN 8'h2A
`define OP_WRMEM 8'h2C
`define OP_RDMEM 8'h2E
`define OP_PTLAREA 8'h30

// Window limits and the least partial span minus one.
`define COL_LIMIT 8'h7F
`define ROW_LIMIT 8'h9F
`define PTL_MIN_SPAN 8'h3F

// Reset values of command-controlled settings and of the port enable.
`define RST_SLEEP_EXIT 1'b0
`define RST_PARTIAL_OFF 1'b1
`define RST_INVERT 1'b0
`define RST_ALLPIX 1'b0
`define RST_DISPLAY_ON 1'b0
`define RST_PORT_EN 1'b1

// Register byte offsets on the software bus.
`define REG_STATUS 5'h00
`define REG_COLWIN 5'h04
`define REG_ROWWIN 5'h08
`define REG_PTLAREA 5'h0C
`define REG_CONTROL 5'h10
`define REG_POSITION 5'h14

// Display memory geometry.
`define RAM_DEPTH 20480

`endif

// *** shared/lcd_port_pkg.sv ***
package lcd_port_pkg;

    typedef enum logic [2:0] {
        BUS_NONE = 3'b000,
        BUS_I80 = 3'b001,
        BUS_M68 = 3'b010,
        BUS_SER4 = 3'b011,
        BUS_SER3 = 3'b100
    } bus_mode_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_COL = 3'b001,
        ST_ROW = 3'b010,
        ST_PTL = 3'b011,
        ST_WR = 3'b100,
        ST_RD = 3'b101
    } dec_state_t;

endpackage

// *** hdl/display_ram_store.sv ***
`timescale 1ns/100ps
`include "lcd_port_defs.svh"

module display_ram_store (
    input wire logic mclk_i,
    input wire logic we_i,
    input wire logic [14:0] addr_i,
    input wire logic [7:0] wdata_i,
    output logic [7:0] rdata_o
);
    logic [7:0] mem_q [0:`RAM_DEPTH-1];

    always_ff @(posedge mclk_i) begin
        if (we_i) begin
            mem_q[addr_i] <= wdata_i;
        end
    end

    // Read is combinational so the caller can register it in its own output stage.
    assign rdata_o = mem_q[addr_i];
endmodule

// *** dv/lcd_host_model.sv ***
`timescale 1ns/100ps
// Host side of the display port; released data lines show the inverse of the last value driven.
module lcd_host_model (
    input wire logic mclk_i,
    input wire logic [7:0] bus_i,
    input wire logic oe_n_i,
    output logic [2:0] sel_o,
    output logic rs_o,
    output logic wr_o,
    output logic rd_o,
    output logic cs_n_o,
    output logic [7:0] data_o
);
    logic cs_off = 1'b0;
    logic m68;
    assign m68 = (sel_o == 3'b100);
    initial begin
        sel_o = 3'b110;
        rs_o = 1'b0;
        wr_o = 1'b1;
        rd_o = 1'b1;
        cs_n_o = 1'b1;
        data_o = 8'h00;
    end
    task automatic setm(input logic [2:0] s);
        @(posedge mclk_i);
        sel_o <= s;
        wr_o <= (s != 3'b100);
        rd_o <= (s != 3'b100);
        rs_o <= 1'b0;
        repeat (2) @(posedge mclk_i);
    endtask
    task automatic put(input logic rs, input logic [7:0] b);
        logic [8:0] v;
        int n;
        v = {rs, b};
        n = (sel_o == 3'b010) ? 9 : 8;
        @(posedge mclk_i);
        cs_n_o <= cs_off;
        if (!sel_o[2]) begin
            for (int i = n - 1; i >= 0; i--) begin
                rs_o <= 1'b0;
                data_o <= {6'h00, rs, v[i]};
                @(posedge mclk_i);
                rs_o <= 1'b1;
                repeat (2) @(posedge mclk_i);
            end
            rs_o <= 1'b0;
        end else begin
            rs_o <= rs;
            data_o <= b;
            wr_o <= 1'b0;
            // The 8080 read strobe must stay high here, or the port would drive the bus.
            rd_o <= 1'b1;
            repeat (2) @(posedge mclk_i);
            wr_o <= !m68;
            rd_o <= !m68;
            repeat (2) @(posedge mclk_i);
        end
        cs_n_o <= 1'b1;
        data_o <= ~data_o;
    endtask
    task automatic get(output logic [7:0] b, output logic [1:0] oe);
        @(posedge mclk_i);
        cs_n_o <= 1'b0;
        rs_o <= 1'b1;
        wr_o <= 1'b1;
        rd_o <= m68;
        repeat (3) @(posedge mclk_i);
        b = bus_i;
        oe[1] = oe_n_i;
        wr_o <= !m68;
        rd_o <= !m68;
        repeat (3) @(posedge mclk_i);
        oe[0] = oe_n_i;
        cs_n_o <= 1'b1;
    endtask
endmodule

// *** dv/test_lcd_host_command_port.sv ***
`timescale 1ns/100ps
`include "lcd_port_defs.svh"
module test_lcd_host_command_port;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic [4:0] avs_address = 5'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [2:0] sel;
    logic rs;
    logic wr;
    logic rd;
    logic cs_n;
    logic [7:0] host_d;
    logic [7:0] dut_d;
    logic [7:0] bus;
    logic oe_n;
    logic [4:0] settings;
    int failures = 0;
    int n_tests = 0;
    // The bus wire follows whichever side drives it.
    assign bus = oe_n ? host_d : dut_d;
    initial forever #25 mclk = ~mclk;
    lcd_cmd_port i_dut (
        .mclk_i(mclk),
        .rst_i(rst),
        .reg_select_i(rs),
        .write_dir_strobe_pin_i(wr),
        .enable_read_strobe_pin_i(rd),
        .bus_sel_lsb_i(sel[0]),
        .bus_sel_mid_i(sel[1]),
        .bus_sel_msb_i(sel[2]),
        .chip_select_n_i(cs_n),
        .data_i(bus),
        .data_o(dut_d),
        .data_oe_n_o(oe_n),
        .sleep_exit_bit_o(settings[0]),
        .partial_off_bit_o(settings[1]),
        .invert_bit_o(settings[2]),
        .all_pixels_bit_o(settings[3]),
        .display_on_o(settings[4]),
        .avs_address_i(avs_address),
        .avs_read_i(avs_read),
        .avs_write_i(avs_write),
        .avs_writedata_i(avs_writedata),
        .avs_readdata_o(avs_readdata),
        .avs_waitrequest_o(avs_waitrequest)
    );
    lcd_host_model i_host (
        .mclk_i(mclk),
        .bus_i(bus),
        .oe_n_i(oe_n),
        .sel_o(sel),
        .rs_o(rs),
        .wr_o(wr),
        .rd_o(rd),
        .cs_n_o(cs_n),
        .data_o(host_d)
    );
    task automatic close_out;
        if (failures == 0 && n_tests > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    // The master waits on waitrequest alone; only the bound ends a wait that never answers.
    task automatic avs(input logic w, input logic [4:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        int n;
        n = 0;
        @(posedge mclk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        do begin
            @(posedge mclk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        q = avs_readdata;
        if (n >= 50) failures++;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    task automatic expect_set(input logic [4:0] e);
        repeat (4) @(posedge mclk);
        chk_byte("settings", {3'h0, e}, {3'h0, settings});
    endtask
    task automatic expect_mode(input logic [2:0] m);
        logic [31:0] q;
        avs(1'b0, `REG_STATUS, 32'h0000_0000, q);
        chk_byte("bus mode", {5'h00, m}, {5'h00, q[10:8]});
    endtask
    task automatic seq(input logic [7:0] op, input logic [7:0] a, input logic [7:0] b);
        i_host.put(1'b0, op);
        i_host.put(1'b1, 8'h00);
        i_host.put(1'b1, a);
        i_host.put(1'b1, 8'h00);
        i_host.put(1'b1, b);
    endtask
    task automatic t_reset;
        logic [31:0] q;
        expect_set(5'h02);
        avs(1'b0, `REG_CONTROL, 32'h0000_0000, q);
        chk_word("control", 32'h0000_0001, q);
        avs(1'b1, 5'h18, 32'hFFFF_FFFF, q);
        avs(1'b0, 5'h18, 32'h0000_0000, q);
        chk_word("unmapped", 32'h0000_0000, q);
        expect_mode(3'h1);
    endtask
    task automatic t_cmds;
        logic [7:0] ops [5];
        logic [4:0] e;
        logic [31:0] q;
        ops = '{`OP_SLEEP, `OP_PARTIAL, `OP_INVERT, `OP_ALLPIX, `OP_DISPLAY};
        e = 5'h02;
        for (int i = 0; i < 5; i++) begin
            i_host.put(1'b0, ops[i] | 8'h01);
            e[i] = 1'b1;
            expect_set(e);
        end
        i_host.put(1'b0, `OP_NOP);
        expect_set(5'h1F);
        avs(1'b1, `REG_CONTROL, 32'h0000_0000, q);
        i_host.put(1'b0, `OP_INVERT);
        expect_set(5'h1F);
        avs(1'b1, `REG_CONTROL, 32'h0000_0001, q);
        i_host.cs_off = 1'b1;
        i_host.put(1'b0, `OP_DISPLAY);
        expect_set(5'h1F);
        i_host.cs_off = 1'b0;
        for (int i = 0; i < 5; i++) begin
            i_host.put(1'b0, ops[i]);
            e[i] = 1'b0;
            expect_set(e);
        end
        i_host.put(1'b0, `OP_SLEEP | 8'h01);
        i_host.put(1'b0, `OP_SWRESET);
        expect_set(5'h02);
        i_host.put(1'b1, `OP_DISPLAY | 8'h01);
        expect_set(5'h02);
    endtask
    task automatic t_window;
        logic [31:0] q;
        logic [7:0] b;
        logic [1:0] oe;
        seq(`OP_COLWIN, 8'h02, 8'h03);
        seq(`OP_COLWIN + 8'h01, 8'h05, 8'h06);
        seq(`OP_COLWIN, 8'h03, 8'h02);
        seq(`OP_COLWIN, 8'h00, 8'h80);
        avs(1'b0, `REG_COLWIN, 32'h0000_0000, q);
        chk_word("column window", 32'h0003_0002, q);
        avs(1'b0, `REG_ROWWIN, 32'h0000_0000, q);
        chk_word("row window", 32'h0006_0005, q);
        seq(`OP_PTLAREA, 8'h10, 8'h4F);
        seq(`OP_PTLAREA, 8'h20, 8'h5E);
        avs(1'b0, `REG_PTLAREA, 32'h0000_0000, q);
        chk_word("partial area", 32'h004F_0010, q);
        i_host.put(1'b0, `OP_WRMEM);
        for (int i = 0; i < 5; i++) i_host.put(1'b1, 8'hA0 + i[7:0]);
        i_host.put(1'b0, `OP_RDMEM);
        for (int i = 0; i < 4; i++) begin
            i_host.get(b, oe);
            chk_byte("read data", (i == 0) ? 8'hA4 : 8'hA0 + i[7:0], b);
            chk_byte("read drive", 8'h01, {6'h00, oe});
        end
        avs(1'b0, `REG_POSITION, 32'h0000_0000, q);
        chk_word("position", 32'h0005_0002, q);
    endtask
    task automatic t_m68;
        logic [7:0] b;
        logic [1:0] oe;
        i_host.setm(3'b100);
        expect_mode(3'h2);
        i_host.put(1'b0, `OP_INVERT | 8'h01);
        expect_set(5'h06);
        i_host.put(1'b0, `OP_RDMEM);
        i_host.get(b, oe);
        chk_byte("read data", 8'hA4, b);
        chk_byte("read drive", 8'h01, {6'h00, oe});
    endtask
    task automatic t_serial;
        i_host.setm(3'b011);
        expect_mode(3'h3);
        i_host.put(1'b0, `OP_DISPLAY | 8'h01);
        expect_set(5'h16);
        i_host.setm(3'b010);
        expect_mode(3'h4);
        i_host.put(1'b0, `OP_ALLPIX | 8'h01);
        expect_set(5'h1E);
    endtask
    initial begin
        repeat (20000) @(posedge mclk);
        failures++;
        close_out();
    end
    initial begin
        repeat (8) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        t_reset();
        t_cmds();
        t_window();
        t_m68();
        t_serial();
        close_out();
    end
endmodule
